// [hdl/pdt_ratio.sv]
// Shift-subtract divider: 64-bit by 32-bit, one quotient bit per cycle.
// Both operands are latched at start; the caller may move them after.
`timescale 1ns/10ps
module pdt_ratio (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic start,
    input wire logic [63:0] dividend,
    input wire logic [31:0] divisor,
    output logic busy,
    output logic done,
    output logic [31:0] quotient
);
    typedef struct packed {
        logic [63:0] rem;
        logic [63:0] quo;
        logic [31:0] dvs;
        logic [6:0] cnt;
        logic busy;
        logic done;
    } pdt_div_type;

    pdt_div_type s_r;
    pdt_div_type s_nxt;
    logic [64:0] trial;

    // One restoring step per cycle; 64 steps cover the widest product
    always_comb begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        trial = {s_r.rem, s_r.quo[63]} - {33'h0, s_r.dvs};
        if (start && !s_r.busy) begin
            s_nxt.rem = 64'h0;
            s_nxt.quo = dividend;
            s_nxt.dvs = divisor;
            s_nxt.cnt = 7'h40;
            s_nxt.busy = 1'b1;
        end else if (s_r.busy) begin
            if (!trial[64]) begin
                s_nxt.rem = trial[63:0];
            end else begin
                s_nxt.rem = {s_r.rem[62:0], s_r.quo[63]};
            end
            s_nxt.quo = {s_r.quo[62:0], ~trial[64]};
            s_nxt.cnt = s_r.cnt - 7'h01;
            if (s_r.cnt == 7'h01) begin
                s_nxt.busy = 1'b0;
                s_nxt.done = 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign busy = s_r.busy;
    assign done = s_r.done;
    // Saturate: a zero divisor gives all ones rather than a trap
    assign quotient = (s_r.quo[63:32] != 32'h0) ? 32'hffff_ffff : s_r.quo[31:0];
endmodule

// [hdl/pdt_top.sv]
// Pulsed drive timer: registers, period timer, trigger qualifier, gate.
// Trigger, limit and regulation inputs are synchronous to hclk.
//
// Added by the designer: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/10ps

// How it works
// - Reset leaves pulsed drive off; output stays in steady mode.
// - Pulsed on/off change accepted only while laser output is off.
// - Enabling outside constant current is refused and flags a mode error.
// - Internal source fires pulses every programmed period while enabled and on.
// - External source gives one pulse per accepted rising trigger edge that arrives while the gate is low.
// - Period is clamped between 1 ms and 5 s.
// - Writing period or frequency recomputes the other as its reciprocal.
// - Duty cycle clamped 0.002% to 99.999%, limited by period.
// - Pulse width clamped 100 us to 1 s for either source.
// - Hold bit picks duty or width kept; other recomputed on period change.
// - External edges closer than minimum period to last accepted are ignored.
// - External mode frequency is measured; writes to it are dropped.
// - At limits set flags, blink output-on lamp, clip the drive.
module pdt_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic laser_output_on,
    input wire logic const_current,
    input wire logic ext_trigger,
    input wire logic at_current_limit,
    input wire logic at_power_limit,
    output logic pulse_gate,
    output logic drive_clip,
    output logic on_lamp,
    output logic irq
);
    typedef enum logic [2:0] {
        CALC_IDLE = 3'b001,
        CALC_DIV = 3'b010,
        CALC_MUL = 3'b100
    } pdt_calc_type;

    typedef struct packed {
        logic wpend;
        logic [7:0] waddr;
        logic pulsed_drive_mode;
        logic ext_src;
        logic hold_width;
        logic [31:0] period;
        logic [31:0] freq;
        logic [31:0] width;
        logic [31:0] duty;
        logic [31:0] minper;
        logic [31:0] meas_freq;
        logic [4:0] ev_stat;
        logic [4:0] ev_mask;
        logic [5:0] pre;
        logic [31:0] phase;
        logic [31:0] since;
        logic seen_edge;
        logic [31:0] gate_cnt;
        logic gate;
        logic trig_d;
        logic lim_d_i;
        logic lim_d_p;
        logic [31:0] blink_cnt;
        logic blink;
        pdt_calc_type calc;
        logic from_freq;
        logic meas_div;
        logic [31:0] rdata;
    } pdt_state_type;

    pdt_state_type s_r;
    pdt_state_type s_nxt;
    logic div_start;
    logic [63:0] div_dividend;
    logic [31:0] div_divisor;
    logic div_busy;
    logic div_done;
    logic [31:0] div_q;
    logic [63:0] prod;
    logic [31:0] act_width;
    logic tick;
    logic start_pulse;
    logic rise;
    logic [31:0] wv;
    logic [4:0] ev;

    // --
    // Helpers
    // --
    function automatic logic [31:0] clamp(input logic [31:0] v, input logic [31:0] lo,
                                          input logic [31:0] hi);
        clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    pdt_ratio u_ratio (
        .hclk(hclk),
        .hresetn(hresetn),
        .start(div_start),
        .dividend(div_dividend),
        .divisor(div_divisor),
        .busy(div_busy),
        .done(div_done),
        .quotient(div_q)
    );

    // Pulse width actually used: never past the period in internal mode
    assign act_width = (!s_r.ext_src && s_r.width >= s_r.period) ?
                       s_r.period - 32'h1 : s_r.width;
    assign tick = (s_r.pre == 6'(pdt_pkg::TICK_CYC - 1));
    assign rise = ext_trigger && !s_r.trig_d;
    assign prod = s_r.hold_width ? 64'(s_r.width) * 64'(pdt_pkg::PPM_FULL) :
                  64'(s_r.duty) * 64'(s_r.period);

    // --
    // Next-state logic
    // --
    always_comb begin
        s_nxt = s_r;
        ev = 5'h0;
        wv = hwdata;
        div_start = 1'b0;
        div_dividend = 64'(pdt_pkg::MHZ_US_PRODUCT);
        div_divisor = s_r.period;
        start_pulse = 1'b0;
        s_nxt.trig_d = ext_trigger;
        s_nxt.pre = tick ? 6'h0 : s_r.pre + 6'h1;

        // Address phase capture; every transfer is zero wait, always OKAY
        if (hsel && hready && htrans[1]) begin
            s_nxt.wpend = hwrite;
            s_nxt.waddr = haddr[7:0];
            unique case (haddr[7:0])
                pdt_pkg::CTRL_OFS: s_nxt.rdata = {29'h0, s_r.hold_width, s_r.ext_src,
                                                  s_r.pulsed_drive_mode};
                pdt_pkg::STAT_OFS: s_nxt.rdata = {26'h0, s_r.gate, at_power_limit,
                                                  at_current_limit, const_current,
                                                  laser_output_on, s_r.pulsed_drive_mode};
                pdt_pkg::IRQ_STAT_OFS: s_nxt.rdata = {27'h0, s_r.ev_stat};
                pdt_pkg::IRQ_MASK_OFS: s_nxt.rdata = {27'h0, s_r.ev_mask};
                pdt_pkg::PERIOD_OFS: s_nxt.rdata = s_r.period;
                pdt_pkg::FREQ_OFS: s_nxt.rdata = s_r.ext_src ? s_r.meas_freq : s_r.freq;
                pdt_pkg::WIDTH_OFS: s_nxt.rdata = act_width;
                pdt_pkg::DUTY_OFS: s_nxt.rdata = s_r.duty;
                pdt_pkg::MINPER_OFS: s_nxt.rdata = s_r.minper;
                default: s_nxt.rdata = 32'h0;
            endcase
        end else begin
            s_nxt.wpend = 1'b0;
        end

        // Data phase writes
        if (s_r.wpend) begin
            unique case (s_r.waddr)
                pdt_pkg::CTRL_OFS: begin
                    s_nxt.ext_src = wv[pdt_pkg::CTRL_EXT];
                    s_nxt.hold_width = wv[pdt_pkg::CTRL_HOLD_WIDTH];
                    if (wv[pdt_pkg::CTRL_PULSED] != s_r.pulsed_drive_mode) begin
                        if (laser_output_on) begin
                            ev[pdt_pkg::EV_REJECT] = 1'b1;
                        end else if (wv[pdt_pkg::CTRL_PULSED] && !const_current) begin
                            ev[pdt_pkg::EV_MODE_ERR] = 1'b1;
                        end else begin
                            s_nxt.pulsed_drive_mode = wv[pdt_pkg::CTRL_PULSED];
                        end
                    end
                end
                pdt_pkg::IRQ_STAT_OFS: s_nxt.ev_stat = s_r.ev_stat & ~wv[4:0];
                pdt_pkg::IRQ_MASK_OFS: s_nxt.ev_mask = wv[4:0];
                pdt_pkg::PERIOD_OFS: begin
                    s_nxt.period = clamp(wv, pdt_pkg::PERIOD_MIN_US,
                                         pdt_pkg::PERIOD_MAX_US);
                    s_nxt.from_freq = 1'b0;
                    s_nxt.calc = CALC_DIV;
                end
                pdt_pkg::FREQ_OFS: begin
                    if (!s_r.ext_src) begin
                        s_nxt.freq = clamp(wv, pdt_pkg::FREQ_MIN_MHZ,
                                           pdt_pkg::FREQ_MAX_MHZ);
                        s_nxt.from_freq = 1'b1;
                        s_nxt.calc = CALC_DIV;
                    end
                end
                pdt_pkg::WIDTH_OFS: begin
                    s_nxt.width = clamp(wv, pdt_pkg::WIDTH_MIN_US,
                                        pdt_pkg::WIDTH_MAX_US);
                    s_nxt.hold_width = 1'b1;
                    s_nxt.calc = CALC_MUL;
                end
                pdt_pkg::DUTY_OFS: begin
                    s_nxt.duty = clamp(wv, pdt_pkg::DUTY_MIN_PPM,
                                       pdt_pkg::DUTY_MAX_PPM);
                    s_nxt.hold_width = 1'b0;
                    s_nxt.calc = CALC_MUL;
                end
                pdt_pkg::MINPER_OFS: s_nxt.minper = clamp(wv, pdt_pkg::PERIOD_MIN_US,
                                                          pdt_pkg::PERIOD_MAX_US);
                default: ;
            endcase
        end

        // Derived values: reciprocal first, then the non-held quantity
        unique case (s_r.calc)
            CALC_IDLE: begin
                if (s_r.meas_div && div_done) begin
                    s_nxt.meas_freq = div_q;
                    s_nxt.meas_div = 1'b0;
                end
            end
            CALC_DIV: begin
                if (div_done && !s_r.meas_div) begin // Done comes with busy low
                    if (s_r.from_freq) begin
                        s_nxt.period = clamp(div_q, pdt_pkg::PERIOD_MIN_US,
                                             pdt_pkg::PERIOD_MAX_US);
                    end else begin
                        s_nxt.freq = div_q;
                    end
                    s_nxt.calc = CALC_MUL;
                end else if (div_done) begin
                    s_nxt.meas_div = 1'b0;
                end else if (!div_busy && !s_r.meas_div) begin
                    div_divisor = s_r.from_freq ? s_r.freq : s_r.period;
                    div_start = 1'b1;
                end
            end
            CALC_MUL: begin
                if (div_done && !s_r.meas_div) begin
                    if (s_r.hold_width) begin
                        s_nxt.duty = clamp(div_q, pdt_pkg::DUTY_MIN_PPM,
                                           pdt_pkg::DUTY_MAX_PPM);
                    end else begin
                        s_nxt.width = clamp(div_q, pdt_pkg::WIDTH_MIN_US,
                                            pdt_pkg::WIDTH_MAX_US);
                    end
                    s_nxt.calc = CALC_IDLE;
                end else if (div_done) begin
                    s_nxt.meas_div = 1'b0;
                end else if (!div_busy && !s_r.meas_div) begin
                    // Held width gives duty; held duty gives width
                    div_dividend = prod;
                    div_divisor = s_r.hold_width ? s_r.period : pdt_pkg::PPM_FULL;
                    div_start = 1'b1;
                end
            end
            default: s_nxt.calc = CALC_IDLE;
        endcase

        // Pulse start sources: internal on the microsecond tick grid, external in the trigger edge cycle
        if (tick) begin
            s_nxt.phase = s_r.phase + 32'h1;
            if (s_r.since != 32'hffff_ffff) begin
                s_nxt.since = s_r.since + 32'h1;
            end
        end
        if (!s_r.pulsed_drive_mode || !laser_output_on || s_r.ext_src) begin
            s_nxt.phase = 32'h0;
        end else if (tick && s_r.phase == 32'h0) begin
            start_pulse = 1'b1;
        end else if (tick && s_r.phase >= s_r.period - 32'h1) begin
            s_nxt.phase = 32'h0;
        end
        if (s_r.ext_src && rise) begin
            if (s_r.seen_edge && s_r.since < s_r.minper) begin
                ev[pdt_pkg::EV_TRIG_DROP] = 1'b1;
            end else begin
                start_pulse = s_r.pulsed_drive_mode && laser_output_on;
                s_nxt.seen_edge = 1'b1;
                s_nxt.since = 32'h0;
                // Measure frequency from the accepted edge interval
                if (s_r.seen_edge && s_r.calc == CALC_IDLE && !div_busy) begin
                    div_divisor = s_r.since;
                    div_start = 1'b1;
                    s_nxt.meas_div = 1'b1;
                end
            end
        end

        // Gate: width counted in ticks; a new start while high is dropped
        if (!s_r.pulsed_drive_mode || !laser_output_on) begin
            s_nxt.gate = 1'b0;
            s_nxt.gate_cnt = 32'h0;
        end else if (start_pulse && !s_r.gate) begin
            s_nxt.gate = 1'b1;
            s_nxt.gate_cnt = 32'h0;
        end else if (s_r.gate && tick) begin
            s_nxt.gate_cnt = s_r.gate_cnt + 32'h1;
            if (s_r.gate_cnt >= act_width - 32'h1) begin
                s_nxt.gate = 1'b0;
            end
        end

        // Limit events and lamp blink
        s_nxt.lim_d_i = at_current_limit;
        s_nxt.lim_d_p = at_power_limit;
        ev[pdt_pkg::EV_ILIM] = at_current_limit && !s_r.lim_d_i;
        ev[pdt_pkg::EV_PLIM] = at_power_limit && !s_r.lim_d_p;
        if (tick) begin
            if (s_r.blink_cnt >= 32'(pdt_pkg::BLINK_TICKS - 1)) begin
                s_nxt.blink_cnt = 32'h0;
                s_nxt.blink = ~s_r.blink;
            end else begin
                s_nxt.blink_cnt = s_r.blink_cnt + 32'h1;
            end
        end

        // Sticky events: a new event beats a same-cycle clear
        s_nxt.ev_stat = s_nxt.ev_stat | ev;
    end

    // --
    // State register
    // --
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_r <= '0;
            s_r.pulsed_drive_mode <= 1'b0;
            s_r.period <= pdt_pkg::PERIOD_RST;
            s_r.freq <= pdt_pkg::FREQ_RST;
            s_r.width <= pdt_pkg::WIDTH_RST;
            s_r.duty <= pdt_pkg::DUTY_RST;
            s_r.minper <= pdt_pkg::MINPER_RST;
            s_r.calc <= CALC_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    // --
    // Outputs
    // --
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = s_r.rdata;
    // Steady mode passes the output state straight through
    assign pulse_gate = s_r.pulsed_drive_mode ? s_r.gate : laser_output_on;
    assign drive_clip = at_current_limit || at_power_limit;
    assign on_lamp = laser_output_on && (!drive_clip || s_r.blink);
    assign irq = |(s_r.ev_stat & s_r.ev_mask);
endmodule

// [inc/pdt_pkg.sv]
// Pulsed drive timer constants: register map, fields, resets, timing.
// Assumes a 40 MHz hclk.
package pdt_pkg;
    // --
    // Clock and time base
    // --
    localparam int CLK_HZ = 40000000;
    localparam int TICK_US = 1;
    localparam int TICK_CYC = CLK_HZ / 1000000 * TICK_US;
    // --
    // Limits: times in microseconds, frequencies in millihertz, duty in ppm
    // --
    localparam logic [31:0] PERIOD_MIN_US = 32'h3e8;
    localparam logic [31:0] PERIOD_MAX_US = 32'h4c_4b40;
    localparam logic [31:0] WIDTH_MIN_US = 32'h64;
    localparam logic [31:0] WIDTH_MAX_US = 32'hf_4240;
    localparam logic [31:0] FREQ_MIN_MHZ = 32'hc8;
    localparam logic [31:0] FREQ_MAX_MHZ = 32'hf_4240;
    localparam logic [31:0] MHZ_US_PRODUCT = 32'h3b9a_ca00;
    localparam logic [31:0] DUTY_MIN_PPM = 32'h14;
    localparam logic [31:0] DUTY_MAX_PPM = 32'hf_4236;
    localparam logic [31:0] PPM_FULL = 32'hf_4240;
    // --
    // Register offsets
    // --
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h0c;
    localparam logic [7:0] PERIOD_OFS = 8'h10;
    localparam logic [7:0] FREQ_OFS = 8'h14;
    localparam logic [7:0] WIDTH_OFS = 8'h18;
    localparam logic [7:0] DUTY_OFS = 8'h1c;
    localparam logic [7:0] MINPER_OFS = 8'h20;
    // --
    // Control fields
    // --
    localparam int CTRL_PULSED = 0;
    localparam int CTRL_EXT = 1;
    localparam int CTRL_HOLD_WIDTH = 2;
    // Status fields
    localparam int STAT_PULSED = 0;
    localparam int STAT_OUT_ON = 1;
    localparam int STAT_CC = 2;
    localparam int STAT_ILIM = 3;
    localparam int STAT_PLIM = 4;
    localparam int STAT_GATE = 5;
    // Interrupt event bits
    localparam int EV_MODE_ERR = 0;
    localparam int EV_REJECT = 1;
    localparam int EV_ILIM = 2;
    localparam int EV_PLIM = 3;
    localparam int EV_TRIG_DROP = 4;
    localparam int EV_BITS = 5;
    // --
    // Reset values and lamp blink timing
    // --
    localparam logic [31:0] PERIOD_RST = 32'h2710;
    localparam logic [31:0] FREQ_RST = 32'h1_86a0;
    localparam logic [31:0] WIDTH_RST = 32'h3e8;
    localparam logic [31:0] DUTY_RST = 32'h1_86a0;
    localparam logic [31:0] MINPER_RST = 32'h3e8;
    localparam int BLINK_MS = 250;
    localparam int BLINK_TICKS = BLINK_MS * 1000 / TICK_US;
endpackage

// [verif/pdt_pulse_partner.sv]
// Far side: trigger source and gate meter.
// Each fire request gives one 8-cycle trigger pulse.
`timescale 1ns/10ps
module pdt_pulse_partner (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic fire,
    input wire logic pulse_gate,
    output logic ext_trigger,
    output logic [15:0] rises,
    output logic [31:0] last_len,
    output logic [31:0] last_gap
);
    logic [3:0] hold_r;
    logic gate_q;
    logic [31:0] len_r;
    logic [31:0] run_r;
    // Trigger held several cycles so only its edge may count
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hold_r <= 4'h0;
            gate_q <= 1'b0;
            {len_r, run_r, last_len, last_gap, rises} <= '0;
        end else begin
            hold_r <= fire ? 4'h8 : hold_r - {3'h0, hold_r != 4'h0};
            gate_q <= pulse_gate;
            run_r <= run_r + 32'h1;
            len_r <= len_r + {31'h0, pulse_gate};
            if (pulse_gate && !gate_q) begin
                rises <= rises + 16'h1;
                last_gap <= run_r;
                run_r <= 32'h1;
                len_r <= 32'h1;
            end
            if (!pulse_gate && gate_q) begin
                last_len <= len_r;
            end
        end
    end
    assign ext_trigger = hold_r != 4'h0;
endmodule

// [verif/pdt_top_monitor.sv]
// Checker for the pulsed drive timer, bound to pdt_top.
// Sees only pdt_top ports, one clock domain.
`timescale 1ns/10ps
module pdt_top_monitor (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic laser_output_on,
    input wire logic at_current_limit,
    input wire logic at_power_limit,
    input wire logic pulse_gate,
    input wire logic drive_clip,
    input wire logic on_lamp,
    input wire logic irq
);
    // --
    // Write tracking
    // --
    logic take;
    logic wrote_r;
    logic [2:0] since_r;
    assign take = hsel && hready && htrans[1];
    // Saturating age of the last write; irq may only drop shortly after one
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wrote_r <= 1'b0;
            since_r <= 3'h7;
        end else if (take && hwrite) begin
            wrote_r <= 1'b1;
            since_r <= 3'h0;
        end else if (since_r != 3'h7) begin
            since_r <= since_r + 3'h1;
        end
    end
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    a_bus_okay: assert property (hreadyout && !hresp) else $error("bus not okay");
    a_clip_limits: assert property (drive_clip == (at_current_limit || at_power_limit))
        else $error("clip mismatch");
    a_gate_needs_on: assert property ($rose(pulse_gate) |-> laser_output_on)
        else $error("gate with output off");
    a_lamp_dark: assert property (!laser_output_on |-> !on_lamp)
        else $error("lamp lit while off");
    a_gate_steady: assert property (!wrote_r |-> pulse_gate == laser_output_on)
        else $error("gate not steady");
    a_rdata_hold: assert property (!$past(take) |-> $stable(hrdata))
        else $error("rdata moved");
    a_irq_clear: assert property ($fell(irq) |-> since_r <= 3'h5)
        else $error("irq fell unprompted");
    a_gate_gap: assert property ($fell(pulse_gate) && laser_output_on |-> !pulse_gate [*8])
        else $error("gate gap short");
endmodule
bind pdt_top pdt_top_monitor u_mon (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .laser_output_on(laser_output_on), .at_current_limit(at_current_limit),
    .at_power_limit(at_power_limit), .pulse_gate(pulse_gate), .drive_clip(drive_clip),
    .on_lamp(on_lamp), .irq(irq));

// [verif/test_pulsed_drive_timer.sv]
// Bench for the pulsed drive timer, one task per scenario.
// Needs pdt_top, pdt_pkg, the bound checker and the partner model.
`timescale 1ns/10ps
module test_pulsed_drive_timer;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, fire = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic laser_output_on = 1'b0, const_current = 1'b1;
    logic at_current_limit = 1'b0, at_power_limit = 1'b0;
    logic hready, hresp, ext_trigger, pulse_gate, drive_clip, on_lamp, irq;
    logic [31:0] hrdata, glen, ggap;
    logic [15:0] rises;
    int n_fail = 0;
    int compares = 0;
    pdt_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
        .hresp(hresp), .hrdata(hrdata), .laser_output_on(laser_output_on),
        .const_current(const_current), .ext_trigger(ext_trigger),
        .at_current_limit(at_current_limit), .at_power_limit(at_power_limit),
        .pulse_gate(pulse_gate), .drive_clip(drive_clip), .on_lamp(on_lamp), .irq(irq));
    pdt_pulse_partner u_far (.hclk(hclk), .hresetn(hresetn), .fire(fire),
        .pulse_gate(pulse_gate), .ext_trigger(ext_trigger), .rises(rises), .last_len(glen),
        .last_gap(ggap));
    // --
    // Clock, checks and bus tasks
    // --
    initial begin
        forever #12.5 hclk = ~hclk;
    end
    task automatic conclude();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, tol, e, input string m);
        compares++;
        if (((got + tol >= e) && (got <= e + tol)) !== 1'b1) begin
            n_fail++;
            $display("mismatch at %0t: %s got %h exp %h", $time, m, got, e);
        end
    endtask
    task automatic ticks(input int n);
        repeat (n) @(posedge hclk);
    endtask
    // Bounded wait; a stall ends the run as a failure
    task automatic wait_until(input logic [15:0] base, input int lim, input logic pulse);
        int n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while ((pulse ? rises === base : hready !== 1'b1) && n < lim);
        if (n >= lim) begin
            n_fail++;
            conclude();
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        wait_until(16'h0, 64, 1'b0);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_until(16'h0, 64, 1'b0);
        r = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(1'b1, a, d, r);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e, input string m);
        logic [31:0] r;
        xfer(1'b0, a, 32'h0, r);
        chk(r, 32'h0, e, m);
    endtask
    // --
    // Scenarios
    // --
    task automatic t_reset();
        rc(8'h00, 32'h0, "ctrl");
        rc(8'h10, pdt_pkg::PERIOD_RST, "period");
        rc(8'h14, pdt_pkg::FREQ_RST, "freq");
        rc(8'h1c, pdt_pkg::DUTY_RST, "duty");
        wr(8'h40, 32'hffff_ffff);
        rc(8'h40, 32'h0, "unmapped");
        laser_output_on <= 1'b1;
        ticks(2);
        chk({31'h0, pulse_gate}, 32'h0, 32'h1, "steady gate");
    endtask
    // Mode interlocks, then irq mask and clear
    task automatic t_lock();
        wr(8'h00, 32'h1);
        rc(8'h00, 32'h0, "toggle on");
        rc(8'h08, 32'h2, "reject ev");
        laser_output_on <= 1'b0;
        const_current <= 1'b0;
        wr(8'h08, 32'h2);
        wr(8'h00, 32'h1);
        rc(8'h00, 32'h0, "not cc");
        rc(8'h08, 32'h1, "mode ev");
        wr(8'h0c, 32'h1f);
        ticks(2);
        chk({31'h0, irq}, 32'h0, 32'h1, "irq set");
        wr(8'h08, 32'h1);
        ticks(2);
        chk({31'h0, irq}, 32'h0, 32'h0, "irq clear");
        const_current <= 1'b1;
    endtask
    // Derived values settle inside 200 cycles
    task automatic t_math();
        wr(8'h18, 32'h32);
        ticks(200);
        wr(8'h10, 32'h7d0);
        ticks(200);
        rc(8'h18, pdt_pkg::WIDTH_MIN_US, "width floor");
        rc(8'h14, 32'h7_a120, "freq 2 ms");
        rc(8'h1c, 32'hc350, "held width");
        wr(8'h10, 32'h1f4);
        ticks(200);
        rc(8'h10, pdt_pkg::PERIOD_MIN_US, "period floor");
        rc(8'h14, pdt_pkg::FREQ_MAX_MHZ, "freq 1 ms");
        rc(8'h1c, 32'h1_86a0, "duty 1 ms");
    endtask
    task automatic t_lim();
        at_current_limit <= 1'b1;
        ticks(3);
        chk({31'h0, drive_clip}, 32'h0, 32'h1, "clip");
        rc(8'h04, 32'hc, "ilim flag");
        rc(8'h08, 32'h4, "ilim ev");
        at_current_limit <= 1'b0;
        at_power_limit <= 1'b1;
        ticks(3);
        rc(8'h04, 32'h14, "plim flag");
        at_power_limit <= 1'b0;
        wr(8'h08, 32'h1f);
    endtask
    // One pulse per edge, early edge dropped, frequency read only
    task automatic t_ext();
        logic [15:0] base;
        logic [31:0] f;
        wr(8'h00, 32'h3);
        rc(8'h00, 32'h3, "enable off");
        laser_output_on <= 1'b1;
        ticks(4);
        base = rises;
        fire <= 1'b1;
        ticks(1);
        fire <= 1'b0;
        wait_until(base, 40, 1'b1);
        ticks(4100);
        chk(glen, 32'd40, 32'd4000, "ext width");
        fire <= 1'b1;
        ticks(1);
        fire <= 1'b0;
        ticks(100);
        chk({16'h0, rises}, 32'h0, {16'h0, base + 16'h1}, "early edge");
        rc(8'h08, 32'h10, "drop ev");
        xfer(1'b0, 8'h14, 32'h0, f);
        wr(8'h14, 32'h1234);
        rc(8'h14, f, "freq ro");
    endtask
    task automatic t_int();
        wr(8'h00, 32'h1);
        wait_until(rises, 45000, 1'b1);
        wait_until(rises, 45000, 1'b1);
        chk(ggap, 32'd40, 32'd40000, "int period");
        ticks(4100);
        chk(glen, 32'd40, 32'd4000, "int width");
        chk({31'h0, on_lamp}, 32'h0, 32'h1, "lamp");
        rc(8'h14, pdt_pkg::FREQ_MAX_MHZ, "freq kept");
    endtask
    initial begin
        ticks(10);
        hresetn <= 1'b1;
        ticks(1);
        t_reset();
        t_lock();
        t_math();
        t_lim();
        t_ext();
        t_int();
        conclude();
    end
    // Watchdog: a hang ends the run as a failure
    initial begin
        ticks(95000);
        n_fail++;
        conclude();
    end
endmodule
